/* File: hw/rvg_pkg.sv */
/*
 * rvg_pkg: constants for the reset sequencer and exception vector generator.
 * assumes: a 100 MHz mclk; used by rvg_top only.
 */
package rvg_pkg;
    // ****************************************************************
    // vector numbers
    // ****************************************************************
    localparam logic [6:0] VEC_RESET      = 7'h00;
    localparam logic [6:0] VEC_DIRECT     = 7'h06;
    localparam logic [6:0] VEC_NMI        = 7'h07;
    localparam logic [6:0] VEC_TRAP0      = 7'h08;
    localparam logic [6:0] VEC_IRQ0       = 7'h10;
    localparam logic [6:0] VEC_IRQ6       = 7'h16;
    localparam logic [6:0] VEC_IRQ7       = 7'h17;
    localparam logic [6:0] VEC_KEY_LO     = 7'h1e;
    localparam logic [6:0] VEC_KEY_HI     = 7'h1f;
    localparam logic [6:0] VEC_WAKE_LO    = 7'h20;
    localparam logic [6:0] VEC_WAKE_HI    = 7'h21;
    localparam logic [6:0] VEC_IRQ8       = 7'h38;
    localparam int         VEC_ADDR_SHIFT = 2;      // four bytes per entry
    localparam int         VEC_ADDR_W     = 24;
    localparam logic [23:0] VEC_TABLE_END = 24'h0001ff;

    // ****************************************************************
    // reset timing and flag reset values
    // ****************************************************************
    localparam int   RESET_MIN_STATES = 20;        // least pin-low time, in states
    localparam int   INIT_CYCLES      = 4;         // cycles spent initialising
    localparam logic CCR_I_RESET      = 1'b1;      // interrupt mask after reset

    // ****************************************************************
    // source selector of a vector request
    // ****************************************************************
    typedef enum logic [3:0] {
        SRC_DIRECT = 4'h0,
        SRC_NMI    = 4'h1,
        SRC_TRAP   = 4'h2,
        SRC_IRQ    = 4'h3,
        SRC_KEY    = 4'h4,
        SRC_WAKE   = 4'h5,
        SRC_PERIPH = 4'h6
    } rvg_src_e;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_INIT  = 2'b01,
        ST_FETCH = 2'b10,
        ST_RUN   = 2'b11
    } rvg_state_e;
endpackage : rvg_pkg

/* File: hw/rvg_sync.sv */
/*
 * rvg_sync: two flip-flop level synchroniser with a reset value.
 * assumes: input comes from outside the mclk domain.
 */
`timescale 1ns/1ns
module rvg_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic mclk,    // system clock
    input  wire logic nrst,    // sync reset, active low
    input  wire logic d_in,    // asynchronous level
    output logic      q_out    // synchronised level
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    // ****************************************************************
    // first stage feeds only the second
    // ****************************************************************
    always_comb begin
        meta_nxt = d_in;
        q_nxt    = meta_r;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta_r <= RST_VAL;
            q_out  <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            q_out  <= q_nxt;
        end
    end
endmodule : rvg_sync

/* File: hw/rvg_top.sv */
/*
 * rvg_top: reset sequencer and exception vector address generator.
 * assumes: the CPU core asks for vectors with vec_req and a source code,
 * reads vec_addr when vec_ack pulses; reset pin, watchdog and low supply causes are async.
 */
// Summary of operation
// - low reset pin halts everything and enters reset; reset beats all sources
// - watchdog overflow or low supply voltage also enters reset
// - after release initialise state and set interrupt mask flag to one
// - then fetch vector 0 from the lowest entry and start there
// - block all interrupts, NMI too, until the first instruction ran
// - extended mode: keyboard low group vector 30, high group vector 31
// - both modes: direct 6, NMI 7, traps 8-11, requests 0-7 at 16-23
// - both modes: wakeup groups at 32 and 33, requests 8-15 at 56-63
// - vectors 24-29, 34-55, 64-127 are peripheral; table ends at 0x1ff
// - one select bit picks compatible (0) or extended (1) table
// - compatible mode: keyboard groups share vectors 22 and 23
`timescale 1ns/1ns
module rvg_top #(
    parameter int INIT_LEN = rvg_pkg::INIT_CYCLES  // initialisation cycles
) (
    input  wire logic        mclk,                  // 100 MHz system clock
    input  wire logic        nrst,                  // sync reset, active low
    input  wire logic        external_reset_pin_n,  // async reset pin, low active
    input  wire logic        wdt_overflow,          // watchdog overflow level, async
    input  wire logic        low_voltage,           // low supply detect level, async
    input  wire logic        extended_vector_select,// 0 compatible, 1 extended
    input  wire logic        vec_req,               // core asks for a vector
    input  wire logic [3:0]  vec_src,               // rvg_src_e source class
    input  wire logic [6:0]  vec_idx,               // index within the class
    input  wire logic        first_insn_done,       // first instruction retired
    output logic             cpu_halt,              // core held in reset
    output logic             periph_init,           // peripheral init pulse, INIT_LEN cycles long
    output logic             ccr_i_set,             // force interrupt mask to one
    output logic             vec_ack,               // vector address valid pulse
    output logic [23:0]      vec_addr,              // vector fetch address
    output logic             pc_load,               // load PC from vec_addr entry
    output logic             irq_block              // interrupts not accepted
);
    // ****************************************************************
    // synchronise reset causes
    // ****************************************************************
    logic pin_n_s;
    logic wdt_s;
    logic lvd_s;

    rvg_sync #(.RST_VAL(1'b0)) u_pin (
        .mclk (mclk),
        .nrst (nrst),
        .d_in (external_reset_pin_n),
        .q_out(pin_n_s)
    );
    rvg_sync #(.RST_VAL(1'b0)) u_wdt (
        .mclk (mclk),
        .nrst (nrst),
        .d_in (wdt_overflow),
        .q_out(wdt_s)
    );
    rvg_sync #(.RST_VAL(1'b0)) u_lvd (
        .mclk (mclk),
        .nrst (nrst),
        .d_in (low_voltage),
        .q_out(lvd_s)
    );

    logic reset_cause;
    // any cause enters reset; pin low is 's partner duty
    assign reset_cause = !pin_n_s || wdt_s || lvd_s;

    // ****************************************************************
    // reset sequencer
    // ****************************************************************
    rvg_pkg::rvg_state_e state_r;
    rvg_pkg::rvg_state_e state_nxt;
    logic [7:0]          cnt_r;
    logic [7:0]          cnt_nxt;
    logic                block_r;
    logic                block_nxt;

    // reset cause overrides any state, so nothing else can win
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        block_nxt = block_r;
        if (reset_cause) begin
            state_nxt = rvg_pkg::ST_RESET;
            cnt_nxt   = 8'h00;
            block_nxt = 1'b1;
        end else begin
            case (state_r)
                rvg_pkg::ST_RESET: begin
                    state_nxt = rvg_pkg::ST_INIT;
                    cnt_nxt   = 8'h00;
                end
                rvg_pkg::ST_INIT: begin
                    cnt_nxt = cnt_r + 8'h01;
                    if (cnt_r == 8'(INIT_LEN - 1)) begin
                        state_nxt = rvg_pkg::ST_FETCH;
                    end
                end
                rvg_pkg::ST_FETCH: begin
                    state_nxt = rvg_pkg::ST_RUN;
                end
                rvg_pkg::ST_RUN: begin
                    // block lifts only once the first instruction retired
                    if (first_insn_done) begin
                        block_nxt = 1'b0;
                    end
                end
                default: state_nxt = rvg_pkg::ST_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= rvg_pkg::ST_RESET;
            cnt_r   <= 8'h00;
            block_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            block_r <= block_nxt;
        end
    end

    // ****************************************************************
    // vector number mapping
    // ****************************************************************
    logic [6:0] vnum;

    // table map per mode; peripheral index passes straight through
    always_comb begin
        vnum = rvg_pkg::VEC_RESET;
        case (vec_src)
            rvg_pkg::SRC_DIRECT: vnum = rvg_pkg::VEC_DIRECT;
            rvg_pkg::SRC_NMI:    vnum = rvg_pkg::VEC_NMI;
            rvg_pkg::SRC_TRAP:   vnum = rvg_pkg::VEC_TRAP0 + {5'h00, vec_idx[1:0]};
            rvg_pkg::SRC_IRQ: begin
                if (vec_idx[3]) begin
                    vnum = rvg_pkg::VEC_IRQ8 + {4'h0, vec_idx[2:0]};
                end else begin
                    vnum = rvg_pkg::VEC_IRQ0 + {4'h0, vec_idx[2:0]};
                end
            end
            rvg_pkg::SRC_KEY: begin
                // mode bit picks own or shared keyboard vectors
                if (extended_vector_select) begin
                    vnum = vec_idx[0] ? rvg_pkg::VEC_KEY_HI : rvg_pkg::VEC_KEY_LO;
                end else begin
                    vnum = vec_idx[0] ? rvg_pkg::VEC_IRQ7 : rvg_pkg::VEC_IRQ6;
                end
            end
            rvg_pkg::SRC_WAKE:
                vnum = vec_idx[0] ? rvg_pkg::VEC_WAKE_HI : rvg_pkg::VEC_WAKE_LO;
            rvg_pkg::SRC_PERIPH: vnum = vec_idx;
            default:             vnum = rvg_pkg::VEC_RESET;
        endcase
    end

    // ****************************************************************
    // output registers
    // ****************************************************************
    logic        ack_nxt;
    logic [23:0] addr_nxt;
    logic        pcl_nxt;

    // reset fetch takes the slot; requests other than traps are refused while blocked
    always_comb begin
        ack_nxt  = 1'b0;
        pcl_nxt  = 1'b0;
        addr_nxt = vec_addr;
        if (state_r == rvg_pkg::ST_FETCH && !reset_cause) begin
            ack_nxt  = 1'b1;
            pcl_nxt  = 1'b1;
            addr_nxt = {17'h00000, rvg_pkg::VEC_RESET} << rvg_pkg::VEC_ADDR_SHIFT;
        end else if (state_r == rvg_pkg::ST_RUN && !reset_cause && vec_req &&
                     !(block_r && vec_src != 4'(rvg_pkg::SRC_TRAP))) begin
            ack_nxt  = 1'b1;
            pcl_nxt  = 1'b1;
            addr_nxt = {17'h00000, vnum} << rvg_pkg::VEC_ADDR_SHIFT;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            vec_ack  <= 1'b0;
            pc_load  <= 1'b0;
            vec_addr <= 24'h000000;
        end else begin
            vec_ack  <= ack_nxt;
            pc_load  <= pcl_nxt;
            vec_addr <= addr_nxt;
        end
    end

    assign cpu_halt    = (state_r == rvg_pkg::ST_RESET);
    assign periph_init = (state_r == rvg_pkg::ST_INIT);
    assign ccr_i_set   = (state_r == rvg_pkg::ST_INIT) & rvg_pkg::CCR_I_RESET;
    assign irq_block   = block_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    localparam int INIT_MAX = 40;

    reset_wins_a: assert property (@(posedge mclk) disable iff (!nrst)
        reset_cause |=> state_r == rvg_pkg::ST_RESET)
        else $error("reset cause did not enter reset");
    halt_in_reset_a: assert property (@(posedge mclk) disable iff (!nrst)
        reset_cause ##1 reset_cause |=> cpu_halt)
        else $error("core not halted during reset");
    init_after_rel_a: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(cpu_halt) |-> periph_init && ccr_i_set)
        else $error("no initialisation after reset release");
    reset_fetch_a: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == rvg_pkg::ST_FETCH && !reset_cause) |=>
        vec_ack && pc_load && vec_addr == 24'h000000)
        else $error("reset vector fetch wrong");
    // a fresh reset cause inside the window restarts the sequence instead
    fetch_bound_a: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(cpu_halt) |-> ##[1:INIT_MAX] (state_r == rvg_pkg::ST_FETCH || reset_cause))
        else $error("reset fetch late");
    block_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        (irq_block && !first_insn_done && vec_req && vec_src == 4'h1) |=> !vec_ack)
        else $error("interrupt accepted while blocked");
    key_ext_a: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == rvg_pkg::ST_RUN && !irq_block && !reset_cause && vec_req &&
         vec_src == 4'h4 && extended_vector_select && !vec_idx[0]) |=>
        vec_addr == 24'h000078)
        else $error("extended keyboard vector wrong");
    key_cmp_a: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == rvg_pkg::ST_RUN && !irq_block && !reset_cause && vec_req &&
         vec_src == 4'h4 && !extended_vector_select && vec_idx[0]) |=>
        vec_addr == 24'h00005c)
        else $error("compatible keyboard vector wrong");
    nmi_vec_a: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == rvg_pkg::ST_RUN && !irq_block && !reset_cause && vec_req &&
         vec_src == 4'h1) |=> vec_ack && vec_addr == 24'h00001c)
        else $error("nmi vector wrong");
    irq_hi_a: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == rvg_pkg::ST_RUN && !irq_block && !reset_cause && vec_req &&
         vec_src == 4'h3 && vec_idx[3:0] == 4'hf) |=> vec_addr == 24'h0000fc)
        else $error("irq15 vector wrong");
    table_end_a: assert property (@(posedge mclk) disable iff (!nrst)
        vec_ack |-> vec_addr + 24'h3 <= rvg_pkg::VEC_TABLE_END)
        else $error("vector outside table");
    addr_x4_a: assert property (@(posedge mclk) disable iff (!nrst)
        vec_ack |-> vec_addr[1:0] == 2'b00)
        else $error("vector address not word aligned");

    reset_seq_c: cover property (@(posedge mclk) disable iff (!nrst)
        $fell(cpu_halt) ##[1:INIT_MAX] pc_load);
    unblock_c: cover property (@(posedge mclk) disable iff (!nrst) $fell(irq_block));
    key_ext_c: cover property (@(posedge mclk) disable iff (!nrst)
        vec_ack && vec_addr == 24'h00007c);
    wdt_c: cover property (@(posedge mclk) disable iff (!nrst) $rose(wdt_s));
endmodule : rvg_top

/* File: tb/rvg_core_model.sv */
/*
 * rvg_core_model: far side of the generator, i.e. the reset source and the core.
 * assumes: the bench pulses rst_go and sets insn_delay; single mclk domain.
 */
`timescale 1ns/1ns
module rvg_core_model #(
    parameter int HOLD_LEN = 20                    // pin-low length, in states
) (
    input  wire logic       mclk,                  // system clock
    input  wire logic       nrst,                  // sync reset, active low
    input  wire logic       rst_go,                // bench asks for a pin reset
    input  wire logic [7:0] insn_delay,            // cycles the first instruction takes
    input  wire logic       cpu_halt,              // core held in reset
    input  wire logic       pc_load,               // start address taken
    output logic            external_reset_pin_n,  // reset pin, low active
    output logic            first_insn_done        // first instruction retired
);
    // ****************************************************************
    // reset pin and first instruction timing
    // ****************************************************************
    int   hold_r;
    int   insn_r;
    logic armed_r;

    // pin idles high like a pulled-up line; once asked it stays low the full length
    assign external_reset_pin_n = (hold_r == 0);
    // the first instruction loads the stack pointer, then reports done once
    assign first_insn_done = (insn_r == 1);

    // countdowns; armed only by a reset so later vector loads do not retrigger
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hold_r  <= 0;
            insn_r  <= 0;
            armed_r <= 1'b1;
        end else begin
            hold_r  <= rst_go ? HOLD_LEN : ((hold_r > 0) ? hold_r - 1 : 0);
            if (cpu_halt)
                armed_r <= 1'b1;
            if (armed_r && pc_load) begin
                insn_r  <= int'(insn_delay) + 2;
                armed_r <= 1'b0;
            end else if (insn_r > 0)
                insn_r <= insn_r - 1;
        end
    end
endmodule : rvg_core_model

/* File: tb/tb_reset_and_vector_generator.sv */
/*
 * tb_reset_and_vector_generator: self-checking bench for rvg_top.
 * assumes: rvg_core_model plays the reset source and the core; 100 MHz mclk.
 */
`timescale 1ns/1ns
module tb_reset_and_vector_generator;
    // ****************************************************************
    // signals, design and far side
    // ****************************************************************
    localparam int INIT_LEN = 3;                   // shortened init phase
    logic        mclk, nrst, rst_go, vec_req, first_insn_done;
    logic        external_reset_pin_n, wdt_overflow, low_voltage, extended_vector_select;
    logic        cpu_halt, periph_init, ccr_i_set, vec_ack, pc_load, irq_block;
    logic [3:0]  vec_src;
    logic [6:0]  vec_idx;
    logic [7:0]  insn_delay;
    logic [23:0] vec_addr;
    logic        got_ack;                          // ack caught at the answer edge
    logic [23:0] got_addr;                         // address caught at the answer edge
    int          n_errors, comparisons;
    int          cycles = 0;

    rvg_top #(.INIT_LEN(INIT_LEN)) u_rvg_top (.mclk(mclk), .nrst(nrst),
        .external_reset_pin_n(external_reset_pin_n), .wdt_overflow(wdt_overflow),
        .low_voltage(low_voltage), .extended_vector_select(extended_vector_select),
        .vec_req(vec_req), .vec_src(vec_src), .vec_idx(vec_idx),
        .first_insn_done(first_insn_done), .cpu_halt(cpu_halt), .periph_init(periph_init),
        .ccr_i_set(ccr_i_set), .vec_ack(vec_ack), .vec_addr(vec_addr), .pc_load(pc_load),
        .irq_block(irq_block));
    rvg_core_model #(.HOLD_LEN(20)) u_rvg_core_model (.mclk(mclk), .nrst(nrst),
        .rst_go(rst_go), .insn_delay(insn_delay), .cpu_halt(cpu_halt), .pc_load(pc_load),
        .external_reset_pin_n(external_reset_pin_n), .first_insn_done(first_insn_done));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %b", $time, what, got);
        end
    endtask : chk_bit

    task automatic chk_addr(input logic [23:0] got, input logic [23:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk_addr

    // inputs always move 1 ns after the edge, so no race with the design
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick

    // one-cycle request; the ack pulse stands only after the first edge, so catch it there
    task automatic req(input logic [3:0] s, input logic [6:0] i);
        vec_req = 1'b1;
        vec_src = s;
        vec_idx = i;
        tick();
        got_ack  = vec_ack;
        got_addr = vec_addr;
        vec_req  = 1'b0;
        tick();
    endtask : req

    task automatic vec(input logic [3:0] s, input logic [6:0] i, input int num);
        req(s, i);
        chk_bit(got_ack, 1'b1, "vector ack");
        chk_addr(got_addr, 24'(num * 4), "vector address");
    endtask : vec

    // bounded wait for a level on one flag, then judge it
    task automatic wait_bit(ref logic sig, input logic exp, input string what);
        for (int k = 0; k < 60 && sig !== exp; k++)
            tick();
        chk_bit(sig, exp, what);
    endtask : wait_bit

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // init phase length, forced mask, then the reset vector fetch
    task automatic boot_check();
        wait_bit(cpu_halt, 1'b0, "halt released");
        for (int i = 0; i < INIT_LEN; i++) begin
            chk_bit(periph_init, 1'b1, "init phase");
            chk_bit(ccr_i_set, 1'b1, "mask forced");
            tick();
        end
        chk_bit(periph_init, 1'b0, "init length");
        tick();
        chk_bit(pc_load, 1'b1, "reset vector load");
        chk_addr(vec_addr, 24'h000000, "reset vector");
        chk_bit(irq_block, 1'b1, "blocked after reset");
    endtask : boot_check

    // interrupts, nmi too, refused until the first instruction is done
    task automatic blocked_check();
        req(4'h1, 7'h00);
        chk_bit(got_ack, 1'b0, "nmi while blocked");
        req(4'h3, 7'h00);
        chk_bit(got_ack, 1'b0, "irq while blocked");
        vec(4'h2, 7'h02, 10);
        wait_bit(irq_block, 1'b0, "block lifted");
        vec(4'h1, 7'h00, 7);
    endtask : blocked_check

    // every source class except NMI in both table modes
    task automatic map_check();
        int plist[6] = '{24, 29, 34, 55, 64, 127};
        for (int m = 0; m < 2; m++) begin
            extended_vector_select = m[0];
            vec(4'h0, 7'h00, 6);
            for (int n = 0; n < 4; n++) vec(4'h2, 7'(n), 8 + n);
            for (int n = 0; n < 8; n++) vec(4'h3, 7'(n), 16 + n);
            for (int n = 8; n < 16; n++) vec(4'h3, 7'(n), 48 + n);
            vec(4'h4, 7'h00, m ? 30 : 22);
            vec(4'h4, 7'h01, m ? 31 : 23);
            vec(4'h5, 7'h00, 32);
            vec(4'h5, 7'h01, 33);
            foreach (plist[p]) vec(4'h6, 7'(plist[p]), plist[p]);
        end
    endtask : map_check

    // pin reset in mid-run: halt, refuse requests, boot again
    task automatic pin_reset(input logic [7:0] delay);
        insn_delay = delay;
        rst_go = 1'b1;
        tick();
        rst_go = 1'b0;
        wait_bit(cpu_halt, 1'b1, "pin halts core");
        req(4'h1, 7'h00);
        chk_bit(got_ack, 1'b0, "nmi during reset");
        boot_check();
        wait_bit(irq_block, 1'b0, "block lifted");
    endtask : pin_reset

    // watchdog overflow (0) or low supply (1) as reset cause
    task automatic cause_reset(input int c);
        wdt_overflow = (c == 0);
        low_voltage = (c == 1);
        wait_bit(cpu_halt, 1'b1, "cause halts core");
        wdt_overflow = 1'b0;
        low_voltage = 1'b0;
        boot_check();
        wait_bit(irq_block, 1'b0, "block lifted");
        vec(4'h3, 7'h0f, 63);
    endtask : cause_reset

    // ****************************************************************
    // clock, timeout and main sequence
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            stop_test();
        end
    end

    initial begin
        {nrst, rst_go, wdt_overflow, low_voltage, extended_vector_select, vec_req} = 6'h00;
        vec_src = 4'h0;
        vec_idx = 7'h00;
        insn_delay = 8'h14;
        n_errors = 0;
        comparisons = 0;
        repeat (8) @(posedge mclk);
        #1;
        nrst = 1'b1;
        boot_check();
        blocked_check();
        map_check();
        pin_reset(8'h00);
        pin_reset(8'h10);
        cause_reset(0);
        cause_reset(1);
        stop_test();
    end
endmodule : tb_reset_and_vector_generator
